// File: src/amrb_pkg.sv
// package: register map, field layouts and constants of the airflow measurement bank
`default_nettype none
package amrb_pkg;
    // register addresses (protocol addresses, 0-based)
    localparam logic [15:0] ADDR_RELATIVE_FLOW       = 16'h0006;
    localparam logic [15:0] ADDR_ABSOLUTE_FLOW_M3H   = 16'h0007;
    localparam logic [15:0] ADDR_SENSOR_ONE_VALUE    = 16'h0008;
    localparam logic [15:0] ADDR_UNUSED_SLOT         = 16'h0009;
    localparam logic [15:0] ADDR_FLOW_SEL_LOW        = 16'h000a;
    localparam logic [15:0] ADDR_FLOW_SEL_HIGH       = 16'h000b;
    localparam logic [15:0] ADDR_ANALOG_SETPOINT     = 16'h000c;
    localparam logic [15:0] ADDR_RELATIVE_PRESSURE   = 16'h0032;
    localparam logic [15:0] ADDR_ABSOLUTE_PRESS_PA   = 16'h0033;
    localparam logic [15:0] ADDR_PRESS_SEL_LOW       = 16'h0035;
    localparam logic [15:0] ADDR_PRESS_SEL_HIGH      = 16'h0036;
    localparam logic [15:0] ADDR_TERMINATION_STATUS  = 16'h0063;

    // value limits
    localparam logic [15:0] INACTIVE_MARKER          = 16'hffff;
    localparam logic [15:0] RELATIVE_FLOW_MAX        = 16'h3a98;     // 15000
    localparam logic [15:0] ANALOG_SETPOINT_MAX      = 16'h2710;     // 10000
    localparam logic [15:0] RELATIVE_PRESSURE_MAX    = 16'h4e20;     // 20000
    localparam logic [31:0] FLOW_SEL_MAX             = 32'h1dcd_6500; // 500000000
    localparam logic [31:0] PRESS_SEL_MAX            = 32'h05f5_e100; // 100000000
    localparam logic [15:0] TERMINATION_RESET        = 16'h0000;

    // application selection codes
    localparam logic [1:0]  APP_FLOW                 = 2'h0;
    localparam logic [1:0]  APP_PRESSURE             = 2'h1;
    localparam logic [1:0]  APP_ROOM_PRESSURE        = 2'h2;

    // sensor type codes
    localparam logic [2:0]  SENSOR_NONE              = 3'h0;
    localparam logic [2:0]  SENSOR_ACTIVE            = 3'h1;
    localparam logic [2:0]  SENSOR_PASSIVE           = 3'h2;
    localparam logic [2:0]  SENSOR_SWITCH            = 3'h4;

    // setpoint source codes
    localparam logic        SOURCE_ANALOG            = 1'b0;

    // live measurements from the control core
    typedef struct packed {
        logic [15:0] relative_flow;
        logic [15:0] absolute_flow_m3h;
        logic [15:0] sensor_mv;
        logic [15:0] sensor_ohm;
        logic        sensor_switch;
        logic [31:0] flow_selected_unit;
        logic [15:0] analog_setpoint;
        logic [15:0] relative_pressure;
        logic signed [15:0] absolute_pressure_pa;
        logic signed [31:0] pressure_selected_unit;
        logic        termination_on;
    } amrb_meas_t;

    // configuration settings held elsewhere in the device
    typedef struct packed {
        logic [1:0]  application;
        logic [2:0]  sensor_type;
        logic        setpoint_source;
    } amrb_cfg_t;

    // register access request from the protocol engine
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } amrb_req_t;

    // answer to the protocol engine
    typedef struct packed {
        logic        valid;
        logic        ok;
        logic        refused;
        logic [15:0] rdata;
    } amrb_rsp_t;
endpackage
`default_nettype wire

// File: src/amrb_clamp.sv
// module: saturates an unsigned measurement to its documented ceiling
`timescale 1ns/1ps
`default_nettype none
module amrb_clamp #(
    parameter int          W   = 16,
    parameter logic [W-1:0] MAX = '1
) (
    input  wire logic [W-1:0] value_in,  // raw value
    output logic      [W-1:0] value_out  // clamped value
);
    assign value_out = (value_in > MAX) ? MAX : value_in;
endmodule // amrb_clamp
`default_nettype wire

// File: src/amrb_snapshot.sv
// module: captures the high half of a 32-bit value when its low word is read, for coherent pairs
`timescale 1ns/1ps
`default_nettype none
module amrb_snapshot (
    input  wire logic        ref_clk,  // system clock
    input  wire logic        rst,      // synchronous reset, active high
    input  wire logic        capture,  // low word read this cycle
    input  wire logic [31:0] live,     // live 32-bit value
    output logic      [15:0] high_word // high half as captured
);
    // a later high-word read returns the half that belongs to the low word already read
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            high_word <= 16'h0000;
        end else if (capture) begin
            high_word <= live[31:16];
        end
    end
endmodule // amrb_snapshot
`default_nettype wire

// File: src/amrb_bank.sv
// module: read-only airflow measurement register bank behind the protocol engine
//
// Function
// - relative flow 0..15000, 0.01 percent steps
// - no-flow applications read flow registers 65535
// - absolute flow m3/h, unsigned 16-bit
// - sensor one shows mV, ohm or switch
// - selected-unit flow low word at address 10
// - selected-unit flow high word at address 11
// - analog setpoint 0..10000, active only analog
// - relative pressure 0..20000, 0.01 percent steps
// - absolute pressure pascal, 0.1 scale, signed
// - selected-unit pressure low word at 53
// - selected-unit pressure high word at 54
// - termination status at 99, default 0
`timescale 1ns/1ps
`default_nettype none
module amrb_bank (
    input  wire logic              ref_clk,  // 40 MHz system clock
    input  wire logic              rst,      // synchronous reset, active high
    input  wire amrb_pkg::amrb_meas_t meas,  // live measurements
    input  wire amrb_pkg::amrb_cfg_t  cfg,   // current settings
    input  wire amrb_pkg::amrb_req_t  req,   // access request, one-cycle valid
    output amrb_pkg::amrb_rsp_t       rsp    // answer, one cycle after request
);
    ////////////////////////////////////////////////////////////////////////////////
    // qualifying conditions

    typedef enum logic [2:0] {
        AMRB_SENSE_NONE   = 3'b001,
        AMRB_SENSE_VOLT   = 3'b010,
        AMRB_SENSE_OTHER  = 3'b100
    } amrb_unused_t;

    logic        flow_active;
    logic        analog_active;
    logic [15:0] rel_flow_c;
    logic [15:0] setpoint_c;
    logic [15:0] rel_press_c;
    logic [31:0] flow_sel_c;
    logic [15:0] flow_high;
    logic [15:0] press_high;
    logic [15:0] sensor_word;
    logic [15:0] next_rdata;
    logic        next_ok;
    logic        low_flow_read;
    logic        low_press_read;
    logic        reading;

    assign flow_active   = (cfg.application == amrb_pkg::APP_FLOW);
    assign analog_active = (cfg.setpoint_source == amrb_pkg::SOURCE_ANALOG);
    assign reading       = req.valid && !req.write;

    ////////////////////////////////////////////////////////////////////////////////
    // range limiting

    amrb_clamp #(.W(16), .MAX(amrb_pkg::RELATIVE_FLOW_MAX)) u_clamp_flow (
        .value_in  (meas.relative_flow),
        .value_out (rel_flow_c)
    );

    amrb_clamp #(.W(16), .MAX(amrb_pkg::ANALOG_SETPOINT_MAX)) u_clamp_setpoint (
        .value_in  (meas.analog_setpoint),
        .value_out (setpoint_c)
    );

    amrb_clamp #(.W(16), .MAX(amrb_pkg::RELATIVE_PRESSURE_MAX)) u_clamp_press (
        .value_in  (meas.relative_pressure),
        .value_out (rel_press_c)
    );

    amrb_clamp #(.W(32), .MAX(amrb_pkg::FLOW_SEL_MAX)) u_clamp_flow_sel (
        .value_in  (meas.flow_selected_unit),
        .value_out (flow_sel_c)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // coherent 32-bit pairs

    // master reads low word first, so the high half is frozen at that moment
    assign low_flow_read  = reading && (req.addr == amrb_pkg::ADDR_FLOW_SEL_LOW);
    assign low_press_read = reading && (req.addr == amrb_pkg::ADDR_PRESS_SEL_LOW);

    amrb_snapshot u_snap_flow (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .capture   (low_flow_read),
        .live      (flow_sel_c),
        .high_word (flow_high)
    );

    amrb_snapshot u_snap_press (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .capture   (low_press_read),
        .live      (meas.pressure_selected_unit),
        .high_word (press_high)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // sensor one meaning

    always_comb begin
        case (cfg.sensor_type)
            amrb_pkg::SENSOR_ACTIVE:  sensor_word = meas.sensor_mv;
            amrb_pkg::SENSOR_PASSIVE: sensor_word = meas.sensor_ohm;
            amrb_pkg::SENSOR_SWITCH:  sensor_word = {15'h0000, meas.sensor_switch};
            default:                  sensor_word = amrb_pkg::INACTIVE_MARKER;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read decode

    always_comb begin
        next_rdata = 16'h0000;
        next_ok    = 1'b1;
        case (req.addr)
            amrb_pkg::ADDR_RELATIVE_FLOW: begin
                next_rdata = flow_active ? rel_flow_c : amrb_pkg::INACTIVE_MARKER;
            end
            amrb_pkg::ADDR_ABSOLUTE_FLOW_M3H: begin
                next_rdata = flow_active ? meas.absolute_flow_m3h
                                         : amrb_pkg::INACTIVE_MARKER;
            end
            amrb_pkg::ADDR_SENSOR_ONE_VALUE: begin
                next_rdata = sensor_word;
            end
            amrb_pkg::ADDR_UNUSED_SLOT: begin
                // the slot exists but holds nothing; answered as an unmapped address
                next_ok = 1'b0;
            end
            amrb_pkg::ADDR_FLOW_SEL_LOW: begin
                next_rdata = flow_active ? flow_sel_c[15:0]
                                         : amrb_pkg::INACTIVE_MARKER;
            end
            amrb_pkg::ADDR_FLOW_SEL_HIGH: begin
                next_rdata = flow_active ? flow_high : amrb_pkg::INACTIVE_MARKER;
            end
            amrb_pkg::ADDR_ANALOG_SETPOINT: begin
                next_rdata = analog_active ? setpoint_c : amrb_pkg::INACTIVE_MARKER;
            end
            amrb_pkg::ADDR_RELATIVE_PRESSURE: begin
                next_rdata = rel_press_c;
            end
            amrb_pkg::ADDR_ABSOLUTE_PRESS_PA: begin
                next_rdata = meas.absolute_pressure_pa;
            end
            amrb_pkg::ADDR_PRESS_SEL_LOW: begin
                next_rdata = meas.pressure_selected_unit[15:0];
            end
            amrb_pkg::ADDR_PRESS_SEL_HIGH: begin
                next_rdata = press_high;
            end
            amrb_pkg::ADDR_TERMINATION_STATUS: begin
                next_rdata = {15'h0000, meas.termination_on};
            end
            default: begin
                next_ok = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // answer register

    // nothing here is ever stored from the bus, so a write only yields a refusal
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp <= '{valid: 1'b0, ok: 1'b0, refused: 1'b0,
                     rdata: amrb_pkg::TERMINATION_RESET};
        end else if (req.valid) begin
            rsp.valid   <= 1'b1;
            rsp.ok      <= !req.write && next_ok;
            rsp.refused <= req.write || !next_ok;
            rsp.rdata   <= req.write ? 16'h0000 : next_rdata;
        end else begin
            rsp.valid   <= 1'b0;
            rsp.ok      <= 1'b0;
            rsp.refused <= 1'b0;
        end
    end
endmodule // amrb_bank
`default_nettype wire

// File: testbench/amrb_bank_props.sv
// checker: port-level properties of the airflow measurement bank
`timescale 1ns/1ps
`default_nettype none
module amrb_bank_props (
    input wire logic                 ref_clk, // clock
    input wire logic                 rst,     // reset
    input wire amrb_pkg::amrb_meas_t meas,    // live values
    input wire amrb_pkg::amrb_cfg_t  cfg,     // settings
    input wire amrb_pkg::amrb_req_t  req,     // request
    input wire amrb_pkg::amrb_rsp_t  rsp      // answer
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic rd;
    assign rd = req.valid && !req.write;
    sequence s_rd(a);
        rd && req.addr == a;
    endsequence
    sequence s_press_pair;
        s_rd(amrb_pkg::ADDR_PRESS_SEL_LOW) ##1 s_rd(amrb_pkg::ADDR_PRESS_SEL_HIGH);
    endsequence
    a_answer_late: assert property (req.valid |=> rsp.valid)
        else $error("answer missing");
    a_no_spurious: assert property (!req.valid |=> !rsp.valid)
        else $error("answer without request");
    a_write_refused: assert property (req.valid && req.write |=>
        rsp.refused && !rsp.ok && rsp.rdata == 16'h0000)
        else $error("write not refused");
    a_slot_refused: assert property (s_rd(amrb_pkg::ADDR_UNUSED_SLOT) |=>
        rsp.refused && !rsp.ok)
        else $error("unused slot answered");
    a_flow_inactive: assert property (s_rd(amrb_pkg::ADDR_ABSOLUTE_FLOW_M3H)
        ##0 cfg.application != amrb_pkg::APP_FLOW |=> rsp.rdata == amrb_pkg::INACTIVE_MARKER)
        else $error("flow not inactive");
    a_flow_high_off: assert property (s_rd(amrb_pkg::ADDR_FLOW_SEL_HIGH)
        ##0 cfg.application != amrb_pkg::APP_FLOW |=> rsp.rdata == amrb_pkg::INACTIVE_MARKER)
        else $error("flow high word not inactive");
    a_abs_flow: assert property (s_rd(amrb_pkg::ADDR_ABSOLUTE_FLOW_M3H)
        ##0 cfg.application == amrb_pkg::APP_FLOW
        |=> rsp.ok && rsp.rdata == $past(meas.absolute_flow_m3h))
        else $error("absolute flow wrong");
    a_relflow_clamp: assert property (s_rd(amrb_pkg::ADDR_RELATIVE_FLOW)
        ##0 cfg.application == amrb_pkg::APP_FLOW |=> rsp.rdata <= amrb_pkg::RELATIVE_FLOW_MAX)
        else $error("relative flow above ceiling");
    a_term_status: assert property (s_rd(amrb_pkg::ADDR_TERMINATION_STATUS) |=>
        rsp.ok && rsp.rdata == {15'h0000, $past(meas.termination_on)})
        else $error("termination status wrong");
    a_press_signed: assert property (s_rd(amrb_pkg::ADDR_ABSOLUTE_PRESS_PA) |=>
        rsp.rdata == $past(meas.absolute_pressure_pa))
        else $error("absolute pressure wrong");
    a_press_pair: assert property (s_press_pair |=>
        rsp.rdata == $past(meas.pressure_selected_unit[31:16], 2))
        else $error("pressure high word not coherent");
    // the master may re-read the last read data between requests; valid, ok and refused clear
    a_rdata_holds: assert property (!req.valid |=> $stable(rsp.rdata))
        else $error("read data not held");
endmodule // amrb_bank_props
bind amrb_bank amrb_bank_props u_props (.ref_clk(ref_clk), .rst(rst), .meas(meas), .cfg(cfg),
    .req(req), .rsp(rsp));
`default_nettype wire

// File: testbench/amrb_master.sv
// partner: protocol-engine side that issues register requests
`timescale 1ns/1ps
`default_nettype none
module amrb_master (
    input wire logic                ref_clk, // clock
    output var amrb_pkg::amrb_req_t req      // request to the bank
);
    initial req = '0;
    // caller sits at a falling edge; valid stays up so calls can run back to back
    task automatic send(input logic w, input logic [15:0] a);
        req = {1'b1, w, a, 16'($urandom)};
        @(negedge ref_clk);
    endtask
    task automatic idle();
        req.valid = 1'b0;
        @(negedge ref_clk);
    endtask
endmodule // amrb_master
`default_nettype wire

// File: testbench/tb.sv
// testbench: self-checking bench of the airflow measurement bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                 ref_clk, rst;
    amrb_pkg::amrb_meas_t meas;
    amrb_pkg::amrb_cfg_t  cfg;
    amrb_pkg::amrb_req_t  req;
    amrb_pkg::amrb_rsp_t  rsp;
    int                   fails, total_checks;
    logic [17:0]          q[$];
    logic [15:0]          fhi, phi;
    logic [191:0]         r;
    logic [15:0]          addrs [13] = '{16'h0006, 16'h0007, 16'h0008, 16'h0009, 16'h000a,
        16'h000b, 16'h000c, 16'h0032, 16'h0033, 16'h0035, 16'h0036, 16'h0063, 16'h0040};
    amrb_bank uut (.ref_clk(ref_clk), .rst(rst), .meas(meas), .cfg(cfg), .req(req), .rsp(rsp));
    amrb_master m (.ref_clk(ref_clk), .req(req));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] mn(logic [15:0] x, logic [15:0] c);
        return (x > c) ? c : x;
    endfunction
    task automatic chk(string n, logic [17:0] e, logic [17:0] s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp=%h got=%h", n, e, s);
        end
    endtask
    task automatic final_report();
        if (fails == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // expectation is taken from the inputs as they stand when the request goes out
    task automatic acc(input logic w, input logic [15:0] a);
        logic fl, ok;
        logic [15:0] v;
        logic [31:0] f;
        fl = cfg.application == amrb_pkg::APP_FLOW;
        f = (meas.flow_selected_unit > amrb_pkg::FLOW_SEL_MAX) ? amrb_pkg::FLOW_SEL_MAX
            : meas.flow_selected_unit;
        ok = !w;
        v = 16'hffff;
        case (a)
            amrb_pkg::ADDR_RELATIVE_FLOW:
                if (fl) v = mn(meas.relative_flow, amrb_pkg::RELATIVE_FLOW_MAX);
            amrb_pkg::ADDR_ABSOLUTE_FLOW_M3H: if (fl) v = meas.absolute_flow_m3h;
            amrb_pkg::ADDR_SENSOR_ONE_VALUE: case (cfg.sensor_type)
                amrb_pkg::SENSOR_ACTIVE: v = meas.sensor_mv;
                amrb_pkg::SENSOR_PASSIVE: v = meas.sensor_ohm;
                amrb_pkg::SENSOR_SWITCH: v = {15'h0000, meas.sensor_switch};
                default: v = 16'hffff;
            endcase
            amrb_pkg::ADDR_FLOW_SEL_LOW: if (fl) v = f[15:0];
            amrb_pkg::ADDR_FLOW_SEL_HIGH: if (fl) v = fhi;
            amrb_pkg::ADDR_ANALOG_SETPOINT: if (cfg.setpoint_source == amrb_pkg::SOURCE_ANALOG)
                v = mn(meas.analog_setpoint, amrb_pkg::ANALOG_SETPOINT_MAX);
            amrb_pkg::ADDR_RELATIVE_PRESSURE:
                v = mn(meas.relative_pressure, amrb_pkg::RELATIVE_PRESSURE_MAX);
            amrb_pkg::ADDR_ABSOLUTE_PRESS_PA: v = meas.absolute_pressure_pa;
            amrb_pkg::ADDR_PRESS_SEL_LOW: v = meas.pressure_selected_unit[15:0];
            amrb_pkg::ADDR_PRESS_SEL_HIGH: v = phi;
            amrb_pkg::ADDR_TERMINATION_STATUS: v = {15'h0000, meas.termination_on};
            default: ok = 1'b0;
        endcase
        q.push_back({ok, !ok, ok ? v : 16'h0000});
        if (!w && a == amrb_pkg::ADDR_FLOW_SEL_LOW) fhi = f[31:16];
        if (!w && a == amrb_pkg::ADDR_PRESS_SEL_LOW) phi = meas.pressure_selected_unit[31:16];
        m.send(w, a);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial forever begin
        @(negedge ref_clk);
        if (rsp.valid === 1'b1) begin
            if (q.size() == 0) chk("rsp", 18'h00000, 18'h3ffff);
            else chk("rsp", q.pop_front(), {rsp.ok, rsp.refused, rsp.rdata});
        end
    end
    initial begin
        #50us;
        fails++;
        final_report();
    end
    initial begin
        rst = 1'b1;
        meas = '0;
        cfg = '0;
        fails = 0;
        total_checks = 0;
        fhi = 16'h0000;
        phi = 16'h0000;
        void'($urandom(41433));
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        chk("reset", 18'h00000, {rsp.ok, rsp.refused, rsp.rdata});
        @(negedge ref_clk);
        meas.flow_selected_unit = 32'h1234_5678;
        meas.pressure_selected_unit = -32'sd5;
        acc(1'b0, amrb_pkg::ADDR_PRESS_SEL_HIGH);
        acc(1'b0, amrb_pkg::ADDR_FLOW_SEL_LOW);
        acc(1'b0, amrb_pkg::ADDR_FLOW_SEL_HIGH);
        acc(1'b0, amrb_pkg::ADDR_PRESS_SEL_LOW);
        acc(1'b0, amrb_pkg::ADDR_PRESS_SEL_HIGH);
        meas.flow_selected_unit = 32'hffff_ffff;
        acc(1'b0, amrb_pkg::ADDR_FLOW_SEL_HIGH);
        acc(1'b0, amrb_pkg::ADDR_FLOW_SEL_LOW);
        acc(1'b0, amrb_pkg::ADDR_FLOW_SEL_HIGH);
        cfg.application = amrb_pkg::APP_PRESSURE;
        acc(1'b0, amrb_pkg::ADDR_FLOW_SEL_HIGH);
        m.idle();
        repeat (300) begin
            r = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            meas = r[$bits(meas)-1:0];
            cfg = {2'($urandom_range(2, 0)), 3'($urandom), 1'($urandom)};
            acc($urandom_range(3, 0) == 0, addrs[$urandom_range(12, 0)]);
        end
        m.idle();
        repeat (3) @(negedge ref_clk);
        // a request that never got an answer would otherwise go unnoticed
        chk("pending", 18'h00000, 18'(q.size()));
        final_report();
    end
endmodule // tb
`default_nettype wire
